// ===== rtl/pbss_fifo.sv
// parameterised valid/ready fifo for write commits
// assumes synchronous active-low reset on mclk
`timescale 1ns/10ps
`default_nettype none
module pbss_fifo
  import pbss_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp_q;
  logic [PW-1:0]    rp_q;
  logic [PW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_q <= PW'(wp_q + 1'b1);
      end
      if (pop)
      begin
        rp_q <= PW'(rp_q + 1'b1);
      end
      cnt_q <= (PW+1)'(cnt_q + push - pop);
    end
  end
endmodule
`default_nettype wire

// ===== rtl/pbss_pkg.sv
// constants and types for the pipelined burst static memory
// assumes a single rising-edge clock domain
// Operation
// - data moves two edges after address sampled
// - clock gate high freezes every register; here the pin synchronisers, snooze flag, write buffer drain and the out_en_n path into lane_data_oe keep running
// - deselect starts nothing, ends current burst
// - pipelined accesses finish after a deselect
// - outputs float two cycles after deselect/write
// - one address gives four beats, 2-bit counter
// - load low loads, high advances burst
// - advance cycles ignore address and direction
// - mode high interleaved, low linear, static
// - address captured only on selected load
// - low address bits seed burst counter
// - strobes ignored when read sampled
// - load cycle direction fixes whole burst
// - deselect when any select false on load
// - output enable high floats data asynchronously; here out_en_n passes a two-flop synchroniser into the registered enable
// - snooze high puts array in standby
// - data paths registered, four 9-bit lanes
// - array holds 131072 words of 36 bits
// - counter wraps after fourth beat, keeps going
// - dummy read / abort write still sequence
// - suspended edge holds read data or float
`default_nettype none
package pbss_pkg;
  localparam int ADDR_W      = 17;
  localparam int LANES       = 4;
  localparam int LANE_W      = 9;
  localparam int WORD_W      = LANES * LANE_W;
  localparam int WORDS       = 131072;
  localparam int FIFO_DEPTH  = 16;
  localparam logic [1:0] BEAT_MASK = 2'h3;

  typedef enum logic [1:0] {PBSS_IDLE, PBSS_READ, PBSS_WRITE} pbss_op_type;

  function automatic logic [1:0] pbss_beat_addr(input logic [1:0] start,
                                                input logic [1:0] idx,
                                                input logic       inter);
    pbss_beat_addr = inter ? (start ^ idx) : 2'((start + idx) & BEAT_MASK);
  endfunction
endpackage
`default_nettype wire

// ===== rtl/pbss_sram.sv
// pipelined burst static memory, 131072 x 36, two-cycle data latency
// assumes host drives pins in mclk domain; pins pass a two-stage synchroniser
`timescale 1ns/10ps
`default_nettype none
module pbss_sram
  import pbss_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic [ADDR_W-1:2]   addr_upper,
  input  wire logic                addr_bit0,
  input  wire logic                addr_bit1,
  input  wire logic                chip_sel_a_n,
  input  wire logic                chip_sel_b_n,
  input  wire logic                chip_sel_b,
  input  wire logic                load_or_advance,
  input  wire logic                clk_gate,
  input  wire logic                rd_wr_n,
  input  wire logic [LANES-1:0]    lane_write_strobe_n,
  input  wire logic                out_en_n,
  input  wire logic                snooze_req,
  input  wire logic                burst_mode,
  input  wire logic [LANES*8-1:0]  lane_data_i,
  input  wire logic [LANES-1:0]    lane_parity_i,
  output logic [LANES*8-1:0]       lane_data_o,
  output logic [LANES-1:0]         lane_parity_o,
  output logic                     lane_data_oe,
  output logic                     snoozing
);
  // two-flop synchronisers for every pin
  logic [ADDR_W+LANES+7-1:0] ctl_m_q;
  logic [ADDR_W+LANES+7-1:0] ctl_s_q;
  logic [WORD_W-1:0]         din_m_q;
  logic [WORD_W-1:0]         din_s_q;

  always_ff @(posedge mclk)
  begin
    ctl_m_q <= {addr_upper, addr_bit1, addr_bit0, chip_sel_a_n, chip_sel_b_n, chip_sel_b,
                load_or_advance, clk_gate, rd_wr_n, lane_write_strobe_n, burst_mode};
    ctl_s_q <= ctl_m_q;
    din_m_q <= {lane_parity_i, lane_data_i};
    din_s_q <= din_m_q;
  end

  logic [ADDR_W-1:0] s_addr;
  logic              s_cs_a_n;
  logic              s_cs_b_n;
  logic              s_cs_b;
  logic              s_lda;
  logic              s_gate;
  logic              s_rw;
  logic [LANES-1:0]  s_bw_n;
  logic              s_mode;
  assign {s_addr, s_cs_a_n, s_cs_b_n, s_cs_b, s_lda, s_gate, s_rw, s_bw_n, s_mode} = ctl_s_q;

  // snooze and output enable are asynchronous levels, also synchronised here
  logic [1:0] oe_sync_q;
  logic [1:0] zz_sync_q;
  always_ff @(posedge mclk)
  begin
    oe_sync_q <= {oe_sync_q[0], out_en_n};
    zz_sync_q <= {zz_sync_q[0], snooze_req};
  end

  logic selected;
  logic edge_ok;
  logic do_load;
  logic do_desel;
  logic do_adv;
  assign selected = !s_cs_a_n && !s_cs_b_n && s_cs_b;
  assign edge_ok  = !s_gate;
  assign do_load  = edge_ok && !s_lda && selected;
  assign do_desel = edge_ok && !s_lda && !selected;
  assign do_adv   = edge_ok && s_lda;

  // burst state
  logic [ADDR_W-1:0] base_q;
  logic [1:0]        idx_q;
  pbss_op_type       burst_op_q;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      base_q     <= '0;
      idx_q      <= 2'h0;
      burst_op_q <= PBSS_IDLE;
    end
    else if (do_load)
    begin
      base_q     <= s_addr;
      idx_q      <= 2'h0;
      burst_op_q <= s_rw ? PBSS_READ : PBSS_WRITE;
    end
    else if (do_desel)
    begin
      burst_op_q <= PBSS_IDLE;
    end
    else if (do_adv && burst_op_q != PBSS_IDLE)
    begin
      idx_q <= 2'(idx_q + 2'h1);
    end
  end

  // current beat address and operation for this edge
  logic [1:0]        nidx;
  logic [ADDR_W-1:0] cur_addr;
  pbss_op_type       cur_op;
  logic [LANES-1:0]  cur_bw;

  always_comb
  begin
    nidx     = 2'(idx_q + 2'h1);
    cur_addr = base_q;
    cur_op   = PBSS_IDLE;
    cur_bw   = '0;
    if (do_load)
    begin
      cur_addr = s_addr;
      cur_op   = s_rw ? PBSS_READ : PBSS_WRITE;
    end
    else if (do_adv && burst_op_q != PBSS_IDLE)
    begin
      cur_addr[1:0] = pbss_beat_addr(base_q[1:0], nidx, s_mode);
      cur_op        = burst_op_q;
    end
    if (cur_op == PBSS_WRITE)
    begin
      cur_bw = ~s_bw_n;
    end
  end

  // two-stage access pipeline
  pbss_op_type       p1_op_q;
  pbss_op_type       p2_op_q;
  logic [ADDR_W-1:0] p1_addr_q;
  logic [ADDR_W-1:0] p2_addr_q;
  logic [LANES-1:0]  p1_bw_q;
  logic [LANES-1:0]  p2_bw_q;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      p1_op_q   <= PBSS_IDLE;
      p2_op_q   <= PBSS_IDLE;
      p1_addr_q <= '0;
      p2_addr_q <= '0;
      p1_bw_q   <= '0;
      p2_bw_q   <= '0;
    end
    else if (edge_ok)
    begin
      p1_op_q   <= cur_op;
      p1_addr_q <= cur_addr;
      p1_bw_q   <= cur_bw;
      p2_op_q   <= p1_op_q;
      p2_addr_q <= p1_addr_q;
      p2_bw_q   <= p1_bw_q;
    end
  end

  // write commits pass through the buffer
  pbss_wr_if wr ();
  logic             commit;
  logic [WORD_W-1:0] rdata;
  assign commit     = edge_ok && p2_op_q == PBSS_WRITE && p2_bw_q != '0;
  assign wr.valid   = commit;
  assign wr.addr    = p2_addr_q;
  assign wr.lane_en = p2_bw_q;
  assign wr.data    = din_s_q;

  logic [WORD_W+ADDR_W+LANES-1:0] fo_data;
  logic                           fo_valid;
  logic                           fo_ready;
  logic                           fifo_in_ready;

  pbss_fifo #(
    .WIDTH (WORD_W + ADDR_W + LANES),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (wr.valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({wr.data, wr.addr, wr.lane_en}),
    .out_valid (fo_valid),
    .out_ready (fo_ready),
    .out_data  (fo_data)
  );
  assign wr.ready = fifo_in_ready;

  // storage array; drains buffer except when a read needs the port or snoozing
  logic [WORD_W-1:0] mem [WORDS];
  logic [WORD_W-1:0] f_word;
  logic [ADDR_W-1:0] f_addr;
  logic [LANES-1:0]  f_en;
  logic              rd_now;
  assign {f_word, f_addr, f_en} = fo_data;
  assign rd_now   = edge_ok && p1_op_q == PBSS_READ;
  assign fo_ready = !zz_sync_q[1] && !rd_now;

  always_ff @(posedge mclk)
  begin
    if (fo_valid && fo_ready)
    begin
      for (int l = 0; l < LANES; l++)
      begin
        if (f_en[l])
        begin
          mem[f_addr][l*8 +: 8]            <= f_word[l*8 +: 8];
          mem[f_addr][LANES*8 + l]         <= f_word[LANES*8 + l];
        end
      end
    end
  end

  // reads take array data with no forwarding from pending buffered writes; hit_pending checks only the buffer head
  logic hit_pending;
  assign hit_pending = fo_valid && f_addr == p1_addr_q;

  always_ff @(posedge mclk)
  begin
    if (rd_now)
    begin
      rdata <= mem[p1_addr_q];
    end
  end

  // output stage: data registered, enable follows op two edges on
  logic rd_out_q;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      lane_data_o   <= '0;
      lane_parity_o <= '0;
      lane_data_oe  <= 1'b0;
      rd_out_q      <= 1'b0;
    end
    else
    begin
      if (edge_ok)
      begin
        rd_out_q <= p2_op_q == PBSS_READ;
      end
      if (edge_ok && rd_out_q == 1'b0 && p1_op_q == PBSS_READ && !hit_pending)
      begin
        lane_data_o   <= '0;
      end
      if (edge_ok && p2_op_q == PBSS_READ)
      begin
        {lane_parity_o, lane_data_o} <= rdata;
      end
      lane_data_oe <= (edge_ok ? (p2_op_q == PBSS_READ) : rd_out_q)
                      && !oe_sync_q[1];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      snoozing <= 1'b0;
    end
    else
    begin
      snoozing <= zz_sync_q[1];
    end
  end
endmodule
`default_nettype wire

// ===== rtl/pbss_wr_if.sv
// write stream carrier between the pipeline and the write buffer
// assumes both ends on mclk
`timescale 1ns/10ps
`default_nettype none
interface pbss_wr_if;
  import pbss_pkg::*;
  logic                valid;
  logic                ready;
  logic [ADDR_W-1:0]   addr;
  logic [LANES-1:0]    lane_en;
  logic [WORD_W-1:0]   data;
  modport src (output valid, output addr, output lane_en, output data, input ready);
  modport snk (input valid, input addr, input lane_en, input data, output ready);
endinterface
`default_nettype wire

// ===== tb/pbss_chk.sv
// pin-level assertions for the burst memory
// assumes bound into pbss_sram, every pin on mclk
`timescale 1ns/10ps
`default_nettype none
module pbss_chk
  import pbss_pkg::*;
(
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire logic               chip_sel_a_n,
  input wire logic               chip_sel_b_n,
  input wire logic               chip_sel_b,
  input wire logic               load_or_advance,
  input wire logic               clk_gate,
  input wire logic               rd_wr_n,
  input wire logic               out_en_n,
  input wire logic               snooze_req,
  input wire logic [LANES*8-1:0] lane_data_o,
  input wire logic [LANES-1:0]   lane_parity_o,
  input wire logic               lane_data_oe,
  input wire logic               snoozing
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic sel = !chip_sel_a_n && !chip_sel_b_n && chip_sel_b;
  wire logic ld  = !load_or_advance && !clk_gate;
  wire logic adv = load_or_advance && !clk_gate;
  sequence calm; (!clk_gate && !out_en_n)[*6]; endsequence
  sequence rd_ld; ld && sel && rd_wr_n; endsequence
  sequence wr_ld; ld && sel && !rd_wr_n; endsequence
  sequence dsel; ld && !sel; endsequence
  chk_read_latency: assert property (rd_ld ##0 calm |-> lane_data_oe)
    else $error("read data not driven in time");
  chk_desel_float: assert property (dsel ##0 calm |-> !lane_data_oe)
    else $error("bus driven after deselect");
  chk_write_float: assert property (wr_ld ##0 calm |-> !lane_data_oe)
    else $error("bus driven during write");
  chk_desel_drain: assert property (rd_ld ##1 dsel ##0 calm |-> !lane_data_oe && $past(lane_data_oe))
    else $error("pending read lost on deselect");
  chk_no_restart: assert property (dsel ##1 adv ##0 calm |-> !lane_data_oe)
    else $error("advance after deselect drove bus");
  chk_burst_wrap: assert property (rd_ld ##1 adv[*4] ##0 calm |-> lane_data_oe)
    else $error("burst stopped after fourth beat");
  chk_gate_hold: assert property (clk_gate |-> ##3 $stable(lane_data_o) && $stable(lane_parity_o))
    else $error("outputs moved on suspended edge");
  chk_gate_oe: assert property (clk_gate && !out_en_n && !$past(out_en_n) |-> ##3 $stable(lane_data_oe))
    else $error("drive enable moved on suspended edge");
  chk_oe_forced: assert property ((out_en_n && !clk_gate)[*6] |-> !lane_data_oe)
    else $error("bus driven with output enable high");
  chk_snooze_on: assert property (snooze_req[*4] |-> snoozing)
    else $error("standby not entered");
  chk_snooze_off: assert property ((!snooze_req)[*4] |-> !snoozing)
    else $error("standby not left");
endmodule
`default_nettype wire

// ===== tb/pbss_host.sv
// host controller model driving the synchronous pins
// assumes cyc is called once for every mclk cycle
`timescale 1ns/10ps
`default_nettype none
module pbss_host
  import pbss_pkg::*;
(
  input wire logic          mclk,
  output logic [ADDR_W-1:2] addr_upper,
  output logic              addr_bit0,
  output logic              addr_bit1,
  output logic              chip_sel_a_n,
  output logic              chip_sel_b_n,
  output logic              chip_sel_b,
  output logic              load_or_advance,
  output logic              clk_gate,
  output logic              rd_wr_n,
  output logic [LANES-1:0]  lane_write_strobe_n,
  output logic [31:0]       lane_data_i,
  output logic [LANES-1:0]  lane_parity_i
);
  logic [WORD_W:0]   p1 = '0;
  logic [WORD_W:0]   p2 = '0;
  logic [WORD_W-1:0] ptn = 36'h5_a5a5_a5a5;
  initial
  begin
    {addr_upper, addr_bit1, addr_bit0} = '0;
    {chip_sel_a_n, chip_sel_b_n, chip_sel_b, load_or_advance} = 4'h0;
    {clk_gate, rd_wr_n, lane_write_strobe_n} = 6'h3f;
    {lane_parity_i, lane_data_i} = '0;
  end
  // sc: 0 selected, 1..3 each select false in turn
  task automatic cyc(input logic adv, input logic [1:0] sc, input logic rd,
                     input logic gt, input logic [ADDR_W-1:0] a,
                     input logic [3:0] be, input logic wv, input logic [WORD_W-1:0] wd);
    @(posedge mclk);
    load_or_advance <= adv;
    chip_sel_a_n <= sc == 2'h1;
    chip_sel_b_n <= sc == 2'h2;
    chip_sel_b <= sc != 2'h3;
    rd_wr_n <= rd;
    clk_gate <= gt;
    {addr_upper, addr_bit1, addr_bit0} <= a;
    lane_write_strobe_n <= be;
    p1 <= {wv, wd};
    p2 <= p1;
    ptn <= ptn + 36'h1_0842_1085;
    // write data two cycles after command, else a moving pattern
    {lane_parity_i, lane_data_i} <= p2[WORD_W] ? p2[WORD_W-1:0] : ptn;
  endtask
endmodule
`default_nettype wire

// ===== tb/pbss_sram_bench.sv
// self-checking bench for the burst memory
// assumes pbss_host drives the synchronous pins
`timescale 1ns/10ps
`default_nettype none
module pbss_sram_bench;
  import pbss_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic out_en_n = 1'b0;
  logic snooze_req = 1'b0;
  logic burst_mode = 1'b1;
  logic [ADDR_W-1:2] addr_upper;
  logic addr_bit0, addr_bit1, chip_sel_a_n, chip_sel_b_n, chip_sel_b;
  logic load_or_advance, clk_gate, rd_wr_n, lane_data_oe, snoozing;
  logic [3:0] lane_write_strobe_n, lane_parity_i, lane_parity_o;
  logic [31:0] lane_data_i, lane_data_o;
  int errors = 0;
  int checks = 0;
  logic [WORD_W-1:0] mem [int];
  logic [WORD_W-1:0] exp_q [$];
  logic [WORD_W-1:0] got_q [$];
  logic prev_oe = 1'b0;
  always #5 mclk = ~mclk;
  pbss_host host_u (.mclk, .addr_upper, .addr_bit0, .addr_bit1, .chip_sel_a_n,
    .chip_sel_b_n, .chip_sel_b, .load_or_advance, .clk_gate, .rd_wr_n,
    .lane_write_strobe_n, .lane_data_i, .lane_parity_i);
  pbss_sram dut_u (.mclk, .rst_n, .addr_upper, .addr_bit0, .addr_bit1, .chip_sel_a_n,
    .chip_sel_b_n, .chip_sel_b, .load_or_advance, .clk_gate, .rd_wr_n,
    .lane_write_strobe_n, .out_en_n, .snooze_req, .burst_mode, .lane_data_i,
    .lane_parity_i, .lane_data_o, .lane_parity_o, .lane_data_oe, .snoozing);
  // collect each new driven word; held words count once
  always @(posedge mclk)
  begin
    if (rst_n && lane_data_oe === 1'b1 && (!prev_oe || got_q[$] !== {lane_parity_o, lane_data_o}))
      got_q.push_back({lane_parity_o, lane_data_o});
    prev_oe = lane_data_oe === 1'b1;
  end
  function automatic logic [ADDR_W-1:0] beat(input logic [ADDR_W-1:0] a, input int i);
    logic [1:0] lo;
    lo = burst_mode ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i);
    return {a[ADDR_W-1:2], lo};
  endfunction
  task automatic end_of_test();
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
    checks++;
    if (e !== g)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int n, input logic [1:0] sc = 2'h3);
    repeat (n) host_u.cyc(1'b0, sc, 1'b1, 1'b0, '0, 4'hf, 1'b0, '0);
  endtask
  // advance beats carry junk address and opposite direction
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [3:0] be,
                    input logic [WORD_W-1:0] d, input int n);
    logic [WORD_W-1:0] w;
    logic [WORD_W-1:0] v;
    for (int i = 0; i < n; i++)
    begin
      v = d + WORD_W'(i);
      host_u.cyc(i > 0, 2'h0, i > 0, 1'b0, i > 0 ? ~a : a, be, 1'b1, v);
      w = mem.exists(beat(a, i)) ? mem[beat(a, i)] : '0;
      for (int l = 0; l < LANES; l++)
        if (!be[l])
        begin
          w[8*l +: 8] = v[8*l +: 8];
          w[32+l] = v[32+l];
        end
      mem[beat(a, i)] = w;
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input int n, input int g = -1);
    for (int i = 0; i < n; i++)
    begin
      host_u.cyc(i > 0, 2'h0, i == 0, 1'b0, i > 0 ? ~a : a, 4'h0, 1'b0, '0);
      exp_q.push_back(mem[beat(a, i)]);
      if (i == g)
        repeat (2) host_u.cyc(1'b1, 2'h0, 1'b0, 1'b1, ~a, 4'h0, 1'b0, '0);
    end
  endtask
  task automatic drain(input string nm);
    idle(10);
    cmp({nm, " count"}, WORD_W'(exp_q.size()), WORD_W'(got_q.size()));
    foreach (exp_q[i])
      cmp(nm, exp_q[i], i < got_q.size() ? got_q[i] : 'x);
    exp_q.delete();
    got_q.delete();
  endtask
  initial
  begin
    idle(2);
    rst_n <= 1'b1;
    idle(3);
    wr(17'h1fff5, 4'h0, 36'h1_0a0b_0c00, 4);
    idle(20);
    burst_mode <= 1'b0;
    idle(3);
    wr(17'h0000a, 4'h0, 36'h2_1a1b_1c10, 4);
    wr(17'h1fff4, 4'ha, 36'hc_5555_5555, 1);
    wr(17'h1fff7, 4'hf, 36'h3_ffff_ffff, 1);
    idle(20, 2'h2);
    rd(17'h1fff4, 4, 1);
    rd(17'h00009, 4);
    drain("burst read");
    rd(17'h00008, 1);
    idle(1, 2'h1);
    repeat (2) host_u.cyc(1'b1, 2'h0, 1'b1, 1'b0, '0, 4'h0, 1'b0, '0);
    drain("deselect");
    out_en_n <= 1'b1;
    idle(2);
    rd(17'h00008, 2);
    exp_q.delete();
    drain("output enable");
    out_en_n <= 1'b0;
    burst_mode <= 1'b1;
    idle(3);
    rd(17'h0000b, 5);
    drain("wrap");
    snooze_req <= 1'b1;
    idle(6);
    cmp("snoozing", WORD_W'(1), {35'h0, snoozing});
    snooze_req <= 1'b0;
    idle(6);
    cmp("snoozing", WORD_W'(0), {35'h0, snoozing});
    end_of_test();
  end
  initial
  begin
    #20us;
    errors++;
    end_of_test();
  end
endmodule
bind pbss_sram pbss_chk chk_u (.mclk, .rst_n, .chip_sel_a_n, .chip_sel_b_n,
  .chip_sel_b, .load_or_advance, .clk_gate, .rd_wr_n, .out_en_n, .snooze_req,
  .lane_data_o, .lane_parity_o, .lane_data_oe, .snoozing);
`default_nettype wire
